// ==== hw/cbc_bus_ctl.sv ====
module cbc_bus_ctl (
  input wire logic mclk, // 200 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  // Core request side
  input wire logic req_valid, // Cycle request
  output logic req_ready, // Request taken this edge
  input wire logic [2:0] req_kind, // Cycle kind
  input wire logic [31:3] req_addr, // Quadword address
  input wire logic [7:0] req_be, // Byte lanes
  input wire logic req_pcd, // Page cacheability from paging
  input wire logic req_pwt, // Page write policy from paging
  input wire logic req_lock, // Part of an atomic sequence
  // Bus pins, outputs
  output logic addr_strobe_n, // Address strobe, low one cycle
  output logic [31:3] addr_out, // Address
  output logic [7:0] be_n_out, // Byte enables, active low
  output logic mem_io_sel, // High memory, low I/O
  output logic data_code_sel, // Cycle definition
  output logic write_read_sel, // High write, low read
  output logic page_no_cache, // Page cache disable
  output logic page_write_through, // Page writethrough
  output logic lock_n, // Bus lock, active low
  output logic parity_error_n, // Read parity error, active low
  output logic snoop_hit_n, // Inquire hit, active low
  // Bus pins, inputs
  input wire logic cacheable_ok_n, // Cache enable, active low
  input wire logic next_addr_ready_n, // Next address, active low
  input wire logic bus_ready_n, // Transfer ready, active low
  input wire logic inquire_start_n, // Inquire strobe, active low
  input wire logic inquire_invalidate_request, // Inquire invalidate
  input wire logic line_policy_select, // High writeback, low writethrough
  input wire logic nmi, // Non-maskable interrupt
  input wire logic [63:0] data_in, // Data bus
  input wire logic [7:0] data_par_in, // Even parity per byte
  // Core read return
  output logic rd_valid, // Read beat, one-cycle pulse
  output logic [63:0] rd_data, // Read data
  output logic rd_fill, // Beat may be cached
  output logic rd_last, // Last beat of the cycle
  output logic [1:0] fill_state, // State for a filled line
  // Core cache side
  input wire logic wr_shared_hit, // Write hit to shared line, pulse
  output logic [1:0] wr_hit_state, // New state for that line
  output logic snoop_req, // Inquire lookup, pulse
  input wire logic snoop_resp_valid, // Lookup answer, pulse
  input wire logic snoop_found, // Line valid in a cache level
  output logic snoop_upd, // Apply new line state, pulse
  output logic [1:0] snoop_new_state, // Invalid or shared
  // Core control
  output logic nmi_take, // Enter non-maskable handler, pulse
  output logic [7:0] nmi_vector, // Vector number
  output logic [31:0] fetch_addr, // Fetch start address
  output logic boot_fetch // Start fetch, pulse after reset
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [cbc_pkg::CBC_PIN_W-1:0] pins_s1_r; // First stage
  logic [cbc_pkg::CBC_PIN_W-1:0] pins_s2_r; // Second stage
  logic [63:0] dat_s; // Synced data
  logic [7:0] par_s; // Synced parity
  logic ken_s; // Synced cacheable-ok, active low
  logic na_s; // Synced next address, active low
  logic brdy_s; // Synced ready, active low
  logic inq_s; // Synced inquire strobe
  logic inv_s; // Synced invalidate select
  logic wbwt_s; // Synced line policy
  logic nmi_s; // Synced interrupt

  // Two flops on every pin
  always_ff @(posedge mclk)
  begin
    pins_s1_r <= {nmi, line_policy_select, inquire_invalidate_request, inquire_start_n,
                  bus_ready_n, next_addr_ready_n, cacheable_ok_n, data_par_in, data_in};
    pins_s2_r <= pins_s1_r;
  end

  assign {nmi_s, wbwt_s, inv_s, inq_s, brdy_s, na_s, ken_s, par_s, dat_s} = pins_s2_r;

  // ****************************************
  // Cycle definition decode
  // ****************************************
  // Returns memory-io, data-code, write-read
  function automatic logic [2:0] cyc_def(input logic [2:0] k);
    logic [2:0] d;
    d = 3'h0;
    case (k)
      cbc_pkg::CBC_MRD: d = 3'h6;
      cbc_pkg::CBC_MWR: d = 3'h7;
      cbc_pkg::CBC_WBACK: d = 3'h7;
      cbc_pkg::CBC_IORD: d = 3'h2;
      cbc_pkg::CBC_IOWR: d = 3'h3;
      cbc_pkg::CBC_INTA: d = 3'h0;
      cbc_pkg::CBC_SPEC: d = 3'h1;
      default: d = 3'h0;
    endcase
    return d;
  endfunction

  // ****************************************
  // Bus sequencer
  // ****************************************
  cbc_pkg::cbc_state_t st_r; // Sequencer state
  logic [2:0] dph_kind_r; // Kind in data phase
  logic [7:0] dph_be_r; // Lanes in data phase
  logic [2:0] pend_kind_r; // Pipelined kind
  logic [7:0] pend_be_r; // Pipelined lanes
  logic pend_r; // Pipelined cycle waiting
  logic na_seen_r; // Next address seen
  logic burst_r; // Current cycle is a burst
  logic [1:0] cnt_r; // Beats done
  logic take; // Request accepted
  logic beat; // Transfer this edge
  logic first; // First beat of cycle
  logic burst_now; // Burst decision on this beat
  logic last; // Final beat of cycle
  logic is_rd; // Data phase is a read

  assign take = req_valid && req_ready;
  assign beat = (st_r == cbc_pkg::CBC_DATA) && !brdy_s;
  assign first = (cnt_r == 2'h0);
  assign is_rd = (dph_kind_r == cbc_pkg::CBC_MRD) || (dph_kind_r == cbc_pkg::CBC_IORD) ||
                 (dph_kind_r == cbc_pkg::CBC_INTA);
  // Writeback always bursts, read bursts only when marked cacheable
  assign burst_now = first ? ((dph_kind_r == cbc_pkg::CBC_WBACK) ||
                              ((dph_kind_r == cbc_pkg::CBC_MRD) && !ken_s))
                           : burst_r;
  assign last = beat && (!burst_now || (cnt_r == cbc_pkg::CBC_LAST_BEAT));
  // Pipelined address accepted once the chipset says so
  assign req_ready = (st_r == cbc_pkg::CBC_IDLE) ||
                     ((st_r == cbc_pkg::CBC_DATA) && na_seen_r && !pend_r && !last);

  // State transitions
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_r <= cbc_pkg::CBC_IDLE;
    end
    else
    begin
      case (st_r)
        cbc_pkg::CBC_IDLE: if (take) st_r <= cbc_pkg::CBC_ADDR;
        cbc_pkg::CBC_ADDR: st_r <= cbc_pkg::CBC_DATA;
        cbc_pkg::CBC_DATA: if (last && !pend_r) st_r <= cbc_pkg::CBC_END;
        cbc_pkg::CBC_END: st_r <= cbc_pkg::CBC_IDLE;
        default: st_r <= cbc_pkg::CBC_IDLE;
      endcase
    end
  end

  // Data phase bookkeeping and pipelining
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dph_kind_r <= 3'h0;
      dph_be_r <= 8'h00;
      pend_kind_r <= 3'h0;
      pend_be_r <= 8'h00;
      pend_r <= 1'b0;
      na_seen_r <= 1'b0;
      burst_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (take && (st_r == cbc_pkg::CBC_IDLE))
      begin
        dph_kind_r <= req_kind;
        dph_be_r <= req_be;
      end
      else if (take)
      begin
        pend_r <= 1'b1;
        pend_kind_r <= req_kind;
        pend_be_r <= req_be;
      end
      if (beat)
      begin
        burst_r <= burst_now;
        cnt_r <= cnt_r + 2'h1;
      end
      if ((st_r == cbc_pkg::CBC_DATA) && !na_s)
        na_seen_r <= 1'b1;
      // Pipelined cycle moves into the data phase
      if (last)
      begin
        cnt_r <= 2'h0;
        na_seen_r <= 1'b0;
        pend_r <= 1'b0;
        if (pend_r)
        begin
          dph_kind_r <= pend_kind_r;
          dph_be_r <= pend_be_r;
        end
      end
    end
  end

  // ****************************************
  // Address phase outputs
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      addr_strobe_n <= 1'b1;
      addr_out <= '0;
      be_n_out <= 8'hff;
      mem_io_sel <= 1'b0;
      data_code_sel <= 1'b0;
      write_read_sel <= 1'b0;
      page_no_cache <= 1'b0;
      page_write_through <= 1'b0;
    end
    else
    begin
      addr_strobe_n <= !take;
      if (take)
      begin
        addr_out <= req_addr;
        be_n_out <= ~req_be;
        {mem_io_sel, data_code_sel, write_read_sel} <= cyc_def(req_kind);
        page_no_cache <= req_pcd;
        page_write_through <= req_pwt;
      end
    end
  end

  // Lock held from the first locked cycle to the first unlocked one, or until idle with no lock request
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      lock_n <= 1'b1;
    else if (take)
      lock_n <= !req_lock;
    else if ((st_r == cbc_pkg::CBC_IDLE) && !req_lock)
      lock_n <= 1'b1;
  end

  // ****************************************
  // Read return, parity and line state
  // ****************************************
  logic [7:0] par_bad; // Per-lane parity failure

  // Even parity over data byte and its parity bit
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      par_bad[i] = dph_be_r[i] && ^{dat_s[i*8 +: 8], par_s[i]};
  end

  // Read beats to the core
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_fill <= 1'b0;
      rd_last <= 1'b0;
      parity_error_n <= 1'b1;
      fill_state <= cbc_pkg::CBC_LS_INV;
    end
    else
    begin
      rd_valid <= beat && is_rd;
      rd_last <= last;
      rd_fill <= beat && is_rd && burst_now;
      parity_error_n <= !(beat && is_rd && (|par_bad));
      if (beat)
        rd_data <= dat_s;
      // Exclusive only for writeback page with writeback line policy
      if (beat && is_rd)
        fill_state <= (!page_write_through && wbwt_s) ? cbc_pkg::CBC_LS_EXC
                                                       : cbc_pkg::CBC_LS_SHR;
    end
  end

  // Write hit to a shared line
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      wr_hit_state <= cbc_pkg::CBC_LS_SHR;
    else if (wr_shared_hit)
      wr_hit_state <= (!page_write_through && wbwt_s) ? cbc_pkg::CBC_LS_EXC
                                                     : cbc_pkg::CBC_LS_SHR;
  end

  // ****************************************
  // Inquire cycles
  // ****************************************
  logic inq_d_r; // Previous strobe level

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      inq_d_r <= 1'b1;
      snoop_req <= 1'b0;
      snoop_upd <= 1'b0;
      snoop_hit_n <= 1'b1;
      snoop_new_state <= cbc_pkg::CBC_LS_INV;
    end
    else
    begin
      inq_d_r <= inq_s;
      snoop_req <= inq_d_r && !inq_s;
      snoop_upd <= snoop_resp_valid && snoop_found;
      if (snoop_resp_valid)
      begin
        snoop_hit_n <= !snoop_found;
        snoop_new_state <= inv_s ? cbc_pkg::CBC_LS_INV : cbc_pkg::CBC_LS_SHR;
      end
    end
  end

  // ****************************************
  // Non-maskable interrupt and reset entry
  // ****************************************
  logic nmi_d_r; // Previous level
  logic boot_r; // Boot pulse issued

  // Rising edge taken with no mask term at all
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      nmi_d_r <= 1'b0;
      nmi_take <= 1'b0;
      nmi_vector <= 8'h00;
    end
    else
    begin
      nmi_d_r <= nmi_s;
      nmi_take <= nmi_s && !nmi_d_r;
      nmi_vector <= cbc_pkg::CBC_NMI_VECTOR;
    end
  end

  // Fetch start after reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fetch_addr <= cbc_pkg::CBC_RESET_FETCH;
      boot_r <= 1'b0;
      boot_fetch <= 1'b0;
    end
    else
    begin
      boot_r <= 1'b1;
      boot_fetch <= !boot_r;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_inq_hit;
    snoop_resp_valid && snoop_found;
  endsequence

  sequence s_rd_first;
    beat && first && (dph_kind_r == cbc_pkg::CBC_MRD);
  endsequence

  property p_inq_state;
    @(posedge mclk) disable iff (!rst_n)
    s_inq_hit |=> snoop_upd && (snoop_new_state == ($past(inv_s) ? 2'h0 : 2'h1));
  endproperty
  a_inq_state: assert property (p_inq_state) else $error("inquire state wrong");

  property p_fill;
    @(posedge mclk) disable iff (!rst_n)
    s_rd_first ##0 !ken_s |=> rd_valid && rd_fill && !rd_last;
  endproperty
  a_fill: assert property (p_fill) else $error("cacheable read not filled");

  property p_nofill;
    @(posedge mclk) disable iff (!rst_n)
    s_rd_first ##0 ken_s && !pend_r |=>
      rd_valid && !rd_fill && rd_last ##1 st_r == cbc_pkg::CBC_IDLE;
  endproperty
  a_nofill: assert property (p_nofill) else $error("uncached read not single");

  property p_wback;
    @(posedge mclk) disable iff (!rst_n)
    beat && first && (dph_kind_r == cbc_pkg::CBC_WBACK) |-> !last;
  endproperty
  a_wback: assert property (p_wback) else $error("writeback not a burst");

  property p_lock;
    @(posedge mclk) disable iff (!rst_n)
    take && req_lock |=> !lock_n;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not asserted");

  property p_mio;
    @(posedge mclk) disable iff (!rst_n)
    take |=> !addr_strobe_n && (mem_io_sel == ($past(req_kind) inside {3'h0, 3'h1, 3'h6}));
  endproperty
  a_mio: assert property (p_mio) else $error("memory-io select wrong");

  property p_nmi;
    @(posedge mclk) disable iff (!rst_n)
    $rose(nmi_s) |=> nmi_take ##1 (nmi_vector == 8'h02) && !nmi_take;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not taken");

  property p_par;
    @(posedge mclk) disable iff (!rst_n)
    beat && is_rd && (|par_bad) |=> !parity_error_n ##1 parity_error_n || rd_valid;
  endproperty
  a_par: assert property (p_par) else $error("parity error missed");

  property p_boot;
    @(posedge mclk)
    !rst_n ##1 rst_n |=> boot_fetch && (fetch_addr == 32'hffff_fff0);
  endproperty
  a_boot: assert property (p_boot) else $error("bad reset fetch");

  property p_hit;
    @(posedge mclk) disable iff (!rst_n)
    s_inq_hit |=> !snoop_hit_n;
  endproperty
  a_hit: assert property (p_hit) else $error("snoop hit missing");

endmodule

// ==== include/cbc_pkg.sv ====
// How it works
// - Inquire hit moves line invalid or shared.
// - Cacheable-ok asserted allows line fill.
// - Cacheable-ok negated gives single uncached transfer.
// - Cacheable-ok ignored during writebacks.
// - Lock held across atomic cycle sequence.
// - Memory-or-I/O select shown every cycle.
// - Select also encodes acknowledge, special cycles.
// - Non-maskable interrupt vectors to 02h.
// - Non-maskable interrupt ignores any software mask.
// - Page-no-cache shows page cacheability.
// - Parity error on bad valid read byte.
// - Page-write-through shows page write policy.
// - Line state from write-through and policy.
// - Reset reinitializes all internal state except the pin synchroniser flops.
// - Fetch starts at FFFF_FFF0h after reset.
// - Snoop-match asserted on valid inquire hit.
package cbc_pkg;
  // ****************************************
  // Cycle kinds requested by the core
  // ****************************************
  typedef enum logic [2:0] {
    CBC_MRD = 3'h0, // Memory read
    CBC_MWR = 3'h1, // Memory write
    CBC_IORD = 3'h2, // I/O read
    CBC_IOWR = 3'h3, // I/O write
    CBC_INTA = 3'h4, // Interrupt acknowledge
    CBC_SPEC = 3'h5, // Special cycle
    CBC_WBACK = 3'h6 // Line writeback
  } cbc_kind_t;

  // ****************************************
  // Bus sequencer states, Gray along the path
  // ****************************************
  typedef enum logic [1:0] {
    CBC_IDLE = 2'h0, // No cycle
    CBC_ADDR = 2'h1, // Address strobe cycle
    CBC_DATA = 2'h3, // Waiting for transfers
    CBC_END = 2'h2 // Bus turnaround
  } cbc_state_t;

  // ****************************************
  // Line states
  // ****************************************
  localparam logic [1:0] CBC_LS_INV = 2'h0; // Invalid
  localparam logic [1:0] CBC_LS_SHR = 2'h1; // Shared
  localparam logic [1:0] CBC_LS_EXC = 2'h2; // Exclusive

  // ****************************************
  // Constants
  // ****************************************
  localparam logic [31:0] CBC_RESET_FETCH = 32'hffff_fff0; // First fetch address
  localparam logic [7:0] CBC_NMI_VECTOR = 8'h02; // Non-maskable vector
  localparam logic [1:0] CBC_LAST_BEAT = 2'h3; // Index of fourth burst beat
  localparam int CBC_PIN_W = 79; // Width of the synchronised pin bundle
endpackage

// ==== verif/cbc_chipset_model.sv ====
// ****
// Chipset side of the processor bus
// ****
module cbc_chipset_model (
  input wire logic mclk, // Bus clock
  input wire logic rst_n, // Reset, active low
  input wire logic addr_strobe_n, // Cycle start from the device
  input wire logic cache_ok, // Answer the cycle as cacheable
  input wire logic [2:0] beats, // Transfers to return
  input wire logic bad_par, // Spoil lane 0 parity
  input wire logic pipe, // Offer a pipelined address during wait states
  output logic cacheable_ok_n, // Cache enable, active low
  output logic next_addr_ready_n, // Next address, active low
  output logic bus_ready_n, // Transfer ready, active low
  output logic [63:0] data_in, // Data bus
  output logic [7:0] data_par_in // Even parity per byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r; // Wait states before the first transfer
  logic [2:0] left_r; // Transfers still owed
  // Next address offered while the wait-state count is not yet zero
  assign next_addr_ready_n = !(pipe && wait_r != 2'h0);
  // Answer each strobe after two wait states
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wait_r <= 2'h0;
      left_r <= 3'h0;
      bus_ready_n <= 1'b1;
      cacheable_ok_n <= 1'b1;
      data_in <= 64'h0;
    end
    else if (!addr_strobe_n)
    begin
      wait_r <= 2'h2;
      left_r <= beats;
      cacheable_ok_n <= !cache_ok; // Held to the last transfer
      bus_ready_n <= 1'b1;
      data_in <= ~data_in;
    end
    else if (wait_r != 2'h0)
    begin
      wait_r <= wait_r - 2'h1;
      data_in <= ~data_in;
    end
    else if (left_r != 3'h0)
    begin
      left_r <= left_r - 3'h1;
      bus_ready_n <= 1'b0;
      data_in <= {left_r, 61'h0123_4567_89ab_cdef};
    end
    else
    begin
      bus_ready_n <= 1'b1;
      cacheable_ok_n <= 1'b1;
      data_in <= ~data_in; // Released bus keeps toggling
    end
  end
  // Even parity per byte, lane 0 spoilt on command
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      data_par_in[i] = (^data_in[8*i +: 8]) ^ (bad_par && i == 0);
  end
endmodule

// ==== verif/cpu_bus_cache_control_pins_test.sv ====
module cpu_bus_cache_control_pins_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Stimulus and observed signals
  // ****
  logic mclk = 1'b0; // 200 MHz clock
  logic rst_n = 1'b0; // Reset, active low
  logic req_valid = 1'b0; // Core request
  logic [2:0] req_kind = 3'h0; // Cycle kind
  logic [31:3] req_addr = 29'h0; // Quadword address
  logic [7:0] req_be = 8'hff; // Byte lanes
  logic req_pcd = 1'b0, req_pwt = 1'b0, req_lock = 1'b0; // Page bits and lock
  logic inquire_start_n = 1'b1, inquire_invalidate_request = 1'b0; // Inquire pins
  logic line_policy_select = 1'b0, nmi = 1'b0; // Policy and interrupt pins
  logic wr_shared_hit = 1'b0, snoop_resp_valid = 1'b0, snoop_found = 1'b0; // Cache side
  logic cache_ok = 1'b0, bad_par = 1'b0, pipe = 1'b0; // Chipset answer modes
  logic [2:0] beats = 3'h1; // Chipset transfer count
  logic req_ready, addr_strobe_n, mem_io_sel, data_code_sel, write_read_sel; // Bus outputs
  logic page_no_cache, page_write_through, lock_n, parity_error_n, snoop_hit_n; // Bus outputs
  logic rd_valid, rd_fill, rd_last, snoop_req, snoop_upd, nmi_take, boot_fetch; // Pulses
  logic [1:0] fill_state, wr_hit_state, snoop_new_state; // Line states
  logic [7:0] be_n_out, nmi_vector; // Lanes and vector
  logic [31:0] fetch_addr; // Fetch start
  logic [31:3] addr_out; // Address pins
  logic cacheable_ok_n, next_addr_ready_n, bus_ready_n; // Chipset pins
  logic [63:0] data_in, rd_data; // Data bus and read return
  logic [7:0] data_par_in; // Data parity
  int fails = 0, samples_checked = 0, cycles = 0; // Tallies
  int n_rd, n_fill, n_last, n_perr, t_last; // Per-cycle observations
  logic [2:0] def_seen; // Cycle definition seen
  logic pn_seen, pw_seen, lock_seen; // Page bits and lock seen
  logic [1:0] fstate; // Fill state seen

  always #2.5 mclk = ~mclk;

  cbc_bus_ctl cbc_bus_ctl_inst (.mclk, .rst_n, .req_valid, .req_ready, .req_kind, .req_addr,
    .req_be, .req_pcd, .req_pwt, .req_lock, .addr_strobe_n, .addr_out, .be_n_out,
    .mem_io_sel, .data_code_sel, .write_read_sel, .page_no_cache, .page_write_through,
    .lock_n, .parity_error_n, .snoop_hit_n, .cacheable_ok_n, .next_addr_ready_n,
    .bus_ready_n, .inquire_start_n, .inquire_invalidate_request, .line_policy_select, .nmi,
    .data_in, .data_par_in, .rd_valid, .rd_data, .rd_fill, .rd_last, .fill_state,
    .wr_shared_hit, .wr_hit_state, .snoop_req, .snoop_resp_valid, .snoop_found, .snoop_upd,
    .snoop_new_state, .nmi_take, .nmi_vector, .fetch_addr, .boot_fetch);

  cbc_chipset_model cbc_chipset_model_inst (.mclk, .rst_n, .addr_strobe_n, .cache_ok,
    .beats, .bad_par, .pipe, .cacheable_ok_n, .next_addr_ready_n, .bus_ready_n, .data_in,
    .data_par_in);

  // ****
  // Shared tasks
  // ****
  // Verdict and end of run
  task automatic tally_and_finish;
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  // Reset, then first fetch
  task automatic apply_reset(input int n);
    rst_n <= 1'b0;
    repeat (n - 1) @(posedge mclk);
    @(negedge mclk);
    chk(lock_n, 1'b1);
    chk(addr_strobe_n, 1'b1);
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk(boot_fetch, 1'b1);
    chk(fetch_addr, 32'hffff_fff0);
    chk(nmi_vector, 8'h02);
    @(negedge mclk);
    chk(boot_fetch, 1'b0);
  endtask
  // One bus cycle, with its returns tallied
  task automatic run_cycle(input logic [2:0] kind, input logic [7:0] be, input logic thru,
    input logic lck, input logic k, input logic [2:0] nb, input logic bp);
    int i;
    @(posedge mclk);
    cache_ok <= k;
    beats <= nb;
    bad_par <= bp;
    req_kind <= kind;
    req_addr <= 29'h1234_5678;
    req_be <= be;
    req_pcd <= !thru;
    req_pwt <= thru;
    req_lock <= lck;
    req_valid <= 1'b1;
    i = 0;
    do @(negedge mclk); while (req_ready !== 1'b1 && ++i < 20);
    @(posedge mclk);
    req_valid <= 1'b0;
    n_rd = 0;
    n_fill = 0;
    n_last = 0;
    n_perr = 0;
    t_last = 0;
    for (i = 1; i < 24; i++)
    begin
      @(negedge mclk);
      if (i == 1)
        {def_seen, pn_seen, pw_seen, lock_seen} = {mem_io_sel, data_code_sel,
          write_read_sel, page_no_cache, page_write_through, lock_n};
      n_rd += int'(rd_valid === 1'b1);
      n_fill += int'(rd_fill === 1'b1);
      n_last += int'(rd_last === 1'b1);
      n_perr += int'(parity_error_n === 1'b0);
      if (rd_valid === 1'b1)
        fstate = fill_state;
      if (rd_last === 1'b1)
        t_last = i;
    end
  endtask
  // Write hit to a shared line
  task automatic wr_hit(input logic [1:0] exp);
    @(posedge mclk);
    wr_shared_hit <= 1'b1;
    @(posedge mclk);
    wr_shared_hit <= 1'b0;
    @(negedge mclk);
    chk(wr_hit_state, exp);
  endtask
  // One inquire with its lookup answer
  task automatic snoop(input logic drop_line, input logic found, input logic [1:0] exp);
    int n;
    @(posedge mclk);
    inquire_invalidate_request <= drop_line;
    inquire_start_n <= 1'b0;
    n = 0;
    do @(negedge mclk); while (snoop_req !== 1'b1 && ++n < 8);
    chk(snoop_req, 1'b1);
    @(posedge mclk);
    inquire_start_n <= 1'b1;
    snoop_resp_valid <= 1'b1;
    snoop_found <= found;
    @(posedge mclk);
    snoop_resp_valid <= 1'b0;
    @(negedge mclk);
    chk(snoop_hit_n, !found);
    chk(snoop_upd, found);
    if (found)
      chk(snoop_new_state, exp);
  endtask

  // ****
  // Scenarios
  // ****
  // Every cycle kind except writeback, uncached single transfers
  task automatic t_kinds;
    logic [2:0] defs [6] = '{3'h6, 3'h7, 3'h2, 3'h3, 3'h0, 3'h1};
    for (int k = 0; k < 6; k++)
    begin
      run_cycle(3'(k), 8'hff, 1'b0, 1'b0, 1'b0, 3'h1, 1'b0);
      chk(def_seen, defs[k]);
      chk(n_rd, (k % 2 == 0) ? 1 : 0);
      chk(n_fill, 0);
      chk(n_last, 1);
    end
  endtask
  // Cached bursts under each page and line policy
  task automatic t_cache;
    @(posedge mclk);
    line_policy_select <= 1'b1;
    run_cycle(3'h0, 8'hff, 1'b0, 1'b0, 1'b1, 3'h4, 1'b0);
    chk(n_rd, 4);
    chk(n_fill, 4);
    chk(fstate, cbc_pkg::CBC_LS_EXC);
    chk({pn_seen, pw_seen}, 2'h2);
    wr_hit(cbc_pkg::CBC_LS_EXC);
    run_cycle(3'h0, 8'hff, 1'b1, 1'b0, 1'b1, 3'h4, 1'b0);
    chk(fstate, cbc_pkg::CBC_LS_SHR);
    chk({pn_seen, pw_seen}, 2'h1);
    wr_hit(cbc_pkg::CBC_LS_SHR);
    @(posedge mclk);
    line_policy_select <= 1'b0;
    run_cycle(3'h0, 8'hff, 1'b0, 1'b0, 1'b1, 3'h4, 1'b0);
    chk(fstate, cbc_pkg::CBC_LS_SHR);
    wr_hit(cbc_pkg::CBC_LS_SHR);
  endtask
  // Writeback length must not follow the cache enable
  task automatic t_wback;
    int t_ok;
    run_cycle(3'h6, 8'hff, 1'b0, 1'b0, 1'b1, 3'h4, 1'b0);
    t_ok = t_last;
    run_cycle(3'h6, 8'hff, 1'b0, 1'b0, 1'b0, 3'h4, 1'b0);
    chk(t_last, t_ok);
    chk(n_last, 1);
    chk(n_rd, 0);
  endtask
  // Parity errors on used and unused lanes
  task automatic t_parity;
    run_cycle(3'h0, 8'hff, 1'b0, 1'b0, 1'b0, 3'h1, 1'b1);
    chk(n_perr, 1);
    chk(rd_data, 64'h2123_4567_89ab_cdef);
    chk(addr_out, 29'h1234_5678);
    run_cycle(3'h0, 8'hfe, 1'b0, 1'b0, 1'b0, 3'h1, 1'b1);
    chk(n_perr, 0);
    chk(be_n_out, 8'h01);
    run_cycle(3'h2, 8'hff, 1'b0, 1'b0, 1'b0, 3'h1, 1'b0);
    chk(n_perr, 0);
    run_cycle(3'h0, 8'hff, 1'b0, 1'b0, 1'b1, 3'h4, 1'b1);
    chk(n_perr, 4);
    run_cycle(3'h1, 8'hff, 1'b0, 1'b0, 1'b0, 3'h1, 1'b1);
    chk(n_perr, 0);
  endtask
  // Lock held across two cycles, then dropped
  task automatic t_lock;
    run_cycle(3'h0, 8'hff, 1'b0, 1'b1, 1'b0, 3'h1, 1'b0);
    chk(lock_seen, 1'b0);
    chk(lock_n, 1'b0);
    run_cycle(3'h1, 8'hff, 1'b0, 1'b1, 1'b0, 3'h1, 1'b0);
    chk(lock_seen, 1'b0);
    run_cycle(3'h0, 8'hff, 1'b0, 1'b0, 1'b0, 3'h1, 1'b0);
    chk(lock_seen, 1'b1);
  endtask
  // Inquire hits and a miss
  task automatic t_snoop;
    snoop(1'b1, 1'b1, cbc_pkg::CBC_LS_INV);
    snoop(1'b0, 1'b1, cbc_pkg::CBC_LS_SHR);
    snoop(1'b1, 1'b0, cbc_pkg::CBC_LS_INV);
  endtask
  // Non-maskable interrupt entry
  task automatic t_nmi;
    int n;
    @(posedge mclk);
    nmi <= 1'b1;
    n = 0;
    do @(negedge mclk); while (nmi_take !== 1'b1 && ++n < 8);
    chk(nmi_take, 1'b1);
    chk(nmi_vector, 8'h02);
    @(negedge mclk);
    chk(nmi_take, 1'b0);
    @(posedge mclk);
    nmi <= 1'b0;
  endtask
  // Second address taken before the first cycle ends
  task automatic t_pipe;
    int n, n_as;
    @(posedge mclk);
    pipe <= 1'b1;
    cache_ok <= 1'b0;
    beats <= 3'h1;
    req_kind <= 3'h0;
    req_valid <= 1'b1;
    n = 0;
    n_as = 0;
    n_rd = 0;
    for (int i = 0; i < 30; i++)
    begin
      @(negedge mclk);
      n_rd += int'(rd_valid === 1'b1);
      if (n_rd == 0)
        n_as += int'(addr_strobe_n === 1'b0);
      if (req_valid && req_ready === 1'b1 && ++n == 2)
      begin
        @(posedge mclk);
        req_valid <= 1'b0;
      end
    end
    @(posedge mclk);
    pipe <= 1'b0;
    chk(n, 2);
    chk(n_as, 2);
    chk(n_rd, 2);
  endtask
  // Reset in the middle of a locked cycle
  task automatic t_midreset;
    @(posedge mclk);
    req_kind <= 3'h0;
    req_lock <= 1'b1;
    req_valid <= 1'b1;
    repeat (4) @(posedge mclk);
    req_valid <= 1'b0;
    req_lock <= 1'b0;
    @(negedge mclk);
    chk(lock_n, 1'b0);
    @(posedge mclk);
    apply_reset(3);
  endtask

  initial
  begin
    apply_reset(16);
    t_kinds;
    t_cache;
    t_wback;
    t_parity;
    t_lock;
    t_snoop;
    t_nmi;
    t_pipe;
    t_midreset;
    tally_and_finish;
  end
endmodule
